// ===== bcs_exec.sv
/*
 * Control-flow execution stage of an 8-bit core: calls, returns, compares,
 * skips and relative branches. One request is taken in the idle state and
 * its result is presented for one cycle on the following edge.
 * Assumes the decoder supplies operands already read from the register
 * file, the addressed I/O register and the stack top, on the same clock.
 */
// Summary of operation
// - Relative call pushes return address, jumps to pc plus k plus one.
// - Indirect call pushes return address, jumps to the Z pointer.
// - Subroutine return pops program counter from stack, flags unchanged.
// - Interrupt return pops program counter and sets global interrupt enable.
// - Compare-skip-equal skips next instruction when both registers match.
// - Register compare subtracts source from destination, updates Z N V C H.
// - Compare with carry also subtracts carry, result discarded, flags updated.
// - Compare immediate subtracts constant, result discarded, flags updated.
// - Skip when the selected working register bit is zero.
// - Skip when the selected working register bit is one, flags untouched.
// - Skip when the selected bit of the read I/O register is zero.
// - Skip when the selected bit of the read I/O register is one.
// - Branch on selected status bit set or clear to pc plus k plus one.
// - Branch if carry set takes the branch only when carry is one.
// - Branch if same or higher takes the branch only when carry is zero.
// - Relative jump loads pc plus k plus one, flags unchanged.
// - Indirect jump loads the Z pointer, no push, flags unchanged.
`include "bcs_cfg.svh"

module bcs_exec (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Request from decode.
   input wire logic op_valid,
   input wire bcs_pkg::bcs_req_t req,
   output logic op_ready,
   // Core state read at the request.
   input wire logic [`BCS_PC_W-1:0] pc_in,
   input wire logic [`BCS_PC_W-1:0] z_ptr,
   input wire logic [`BCS_PC_W-1:0] stack_top,
   input wire logic [7:0] status_flags_reg,
   // Result toward program counter, stack and status flags.
   output bcs_pkg::bcs_res_t res
);
   import bcs_pkg::*;

   bcs_core_t q_reg;
   bcs_core_t q_next;
   logic [`BCS_PC_W-1:0] seq_pc;
   logic [`BCS_PC_W-1:0] rel_pc;
   logic [`BCS_PC_W-1:0] skip_pc;
   logic [7:0] cmp_b;
   logic cmp_cin;
   logic cmp_chain;
   logic [7:0] cmp_flags;
   logic take;

   // Offset sign extension lets targets lie before or after the instruction.
   assign seq_pc = pc_in + `BCS_PC_STEP;
   assign rel_pc = seq_pc + {{(`BCS_PC_W-`BCS_OFF_W){req.offset[`BCS_OFF_W-1]}}, req.offset};
   assign skip_pc = pc_in + (req.next_two_word ? `BCS_SKIP_TWO : `BCS_SKIP_ONE);
   assign op_ready = (q_reg.st == bcs_st_idle);
   assign take = op_valid && op_ready;
   assign res = q_reg.res;

   // Subtraction flags; the carry form keeps Z only while the chain stays zero.
   function automatic logic [7:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin, input logic chain,
                                            input logic [7:0] fin);
      logic [7:0] r;
      logic [7:0] f;
      r = a - b - {7'h00, cin};
      f = fin;
      f[`BCS_FLAG_H] = (~a[`BCS_NIB_MSB] & b[`BCS_NIB_MSB]) | (b[`BCS_NIB_MSB] & r[`BCS_NIB_MSB])
                       | (r[`BCS_NIB_MSB] & ~a[`BCS_NIB_MSB]);
      f[`BCS_FLAG_C] = (~a[`BCS_MSB] & b[`BCS_MSB]) | (b[`BCS_MSB] & r[`BCS_MSB])
                       | (r[`BCS_MSB] & ~a[`BCS_MSB]);
      f[`BCS_FLAG_V] = (a[`BCS_MSB] & ~b[`BCS_MSB] & ~r[`BCS_MSB])
                       | (~a[`BCS_MSB] & b[`BCS_MSB] & r[`BCS_MSB]);
      f[`BCS_FLAG_N] = r[`BCS_MSB];
      f[`BCS_FLAG_Z] = (r == 8'h00) && (!chain || fin[`BCS_FLAG_Z]);
      return f;
   endfunction

   always_comb begin
      cmp_b = req.rr_val;
      cmp_cin = 1'b0;
      cmp_chain = 1'b0;
      if (req.op == bcs_op_compare_immediate) begin
         cmp_b = req.imm_val;
      end
      if (req.op == bcs_op_compare_with_carry) begin
         cmp_cin = status_flags_reg[`BCS_FLAG_C];
         cmp_chain = 1'b1;
      end
      cmp_flags = sub_flags(req.rd_val, cmp_b, cmp_cin, cmp_chain, status_flags_reg);
   end

   always_comb begin
      q_next = q_reg;
      q_next.res.done = 1'b0;
      q_next.res.pc_load = 1'b0;
      q_next.res.push_en = 1'b0;
      q_next.res.pop_en = 1'b0;
      q_next.res.flags_we = 1'b0;
      case (q_reg.st)
         bcs_st_idle: begin
            if (op_valid) begin
               q_next.st = bcs_st_result;
               q_next.res.done = 1'b1;
               q_next.res.pc_load = 1'b1;
               q_next.res.pc_next = seq_pc;
               q_next.res.flags = status_flags_reg;
               case (req.op)
                  bcs_op_relative_call: begin
                     q_next.res.push_en = 1'b1;
                     q_next.res.push_data = seq_pc;
                     q_next.res.pc_next = rel_pc;
                  end
                  bcs_op_indirect_call: begin
                     q_next.res.push_en = 1'b1;
                     q_next.res.push_data = seq_pc;
                     q_next.res.pc_next = z_ptr;
                  end
                  bcs_op_subroutine_return: begin
                     q_next.res.pop_en = 1'b1;
                     q_next.res.pc_next = stack_top;
                  end
                  bcs_op_interrupt_return: begin
                     q_next.res.pop_en = 1'b1;
                     q_next.res.pc_next = stack_top;
                     q_next.res.flags_we = 1'b1;
                     q_next.res.flags[`BCS_FLAG_I] = 1'b1;
                  end
                  bcs_op_compare_skip_equal: begin
                     if (req.rd_val == req.rr_val) begin
                        q_next.res.pc_next = skip_pc;
                     end
                  end
                  bcs_op_compare_reg, bcs_op_compare_with_carry, bcs_op_compare_immediate: begin
                     q_next.res.flags_we = 1'b1;
                     q_next.res.flags = cmp_flags;
                  end
                  bcs_op_skip_reg_bit_clear: begin
                     if (!req.rr_val[req.bit_sel]) begin
                        q_next.res.pc_next = skip_pc;
                     end
                  end
                  bcs_op_skip_reg_bit_set: begin
                     if (req.rr_val[req.bit_sel]) begin
                        q_next.res.pc_next = skip_pc;
                     end
                  end
                  bcs_op_skip_io_bit_clear: begin
                     if (!req.io_val[req.bit_sel]) begin
                        q_next.res.pc_next = skip_pc;
                     end
                  end
                  bcs_op_skip_io_bit_set: begin
                     if (req.io_val[req.bit_sel]) begin
                        q_next.res.pc_next = skip_pc;
                     end
                  end
                  bcs_op_branch_flag_set: begin
                     if (status_flags_reg[req.bit_sel]) begin
                        q_next.res.pc_next = rel_pc;
                     end
                  end
                  bcs_op_branch_flag_clear: begin
                     if (!status_flags_reg[req.bit_sel]) begin
                        q_next.res.pc_next = rel_pc;
                     end
                  end
                  bcs_op_branch_carry_set: begin
                     if (status_flags_reg[`BCS_FLAG_C]) begin
                        q_next.res.pc_next = rel_pc;
                     end
                  end
                  bcs_op_branch_same_or_higher: begin
                     if (!status_flags_reg[`BCS_FLAG_C]) begin
                        q_next.res.pc_next = rel_pc;
                     end
                  end
                  bcs_op_relative_jump: begin
                     q_next.res.pc_next = rel_pc;
                  end
                  bcs_op_indirect_jump: begin
                     q_next.res.pc_next = z_ptr;
                  end
                  default: begin
                     q_next.res.pc_next = seq_pc;
                  end
               endcase
            end
         end
         bcs_st_result: begin
            q_next.st = bcs_st_idle;
         end
         default: begin
            q_next.st = bcs_st_idle;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q_reg.st <= bcs_st_idle;
         q_reg.res.done <= 1'b0;
         q_reg.res.pc_load <= 1'b0;
         q_reg.res.pc_next <= `BCS_WORD_RST;
         q_reg.res.push_en <= 1'b0;
         q_reg.res.push_data <= `BCS_WORD_RST;
         q_reg.res.pop_en <= 1'b0;
         q_reg.res.flags_we <= 1'b0;
         q_reg.res.flags <= `BCS_FLAGS_RST;
      end else begin
         q_reg <= q_next;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   call_target_a: assert property (take && req.op == bcs_op_relative_call |=>
      res.push_en && res.push_data == $past(seq_pc) && res.pc_next == $past(rel_pc)
      && !res.flags_we)
      else $error("relative call target or push wrong");
   zptr_call_a: assert property (take && req.op == bcs_op_indirect_call |=>
      res.push_en && res.pc_next == $past(z_ptr) && !res.flags_we)
      else $error("indirect call target wrong");
   return_pop_a: assert property (take && req.op == bcs_op_subroutine_return |=>
      res.pop_en && res.pc_next == $past(stack_top) && !res.flags_we)
      else $error("subroutine return wrong");
   irq_return_a: assert property (take && req.op == bcs_op_interrupt_return |=>
      res.pop_en && res.flags_we && res.flags[`BCS_FLAG_I])
      else $error("interrupt return did not set enable");
   equal_skip_a: assert property (take && req.op == bcs_op_compare_skip_equal
      && req.rd_val == req.rr_val && !req.next_two_word |=> res.pc_next == $past(pc_in) + 16'h0002)
      else $error("compare skip equal step wrong");
   cmp_zero_a: assert property (take && req.op == bcs_op_compare_reg
      && req.rd_val == req.rr_val |=> res.flags_we && res.flags[`BCS_FLAG_Z] && !res.flags[`BCS_FLAG_C])
      else $error("equal compare flags wrong");
   carry_cmp_a: assert property (take && req.op == bcs_op_compare_with_carry
      && req.rd_val == req.rr_val && status_flags_reg[`BCS_FLAG_C] |=> res.flags[`BCS_FLAG_C]
      && res.flags[`BCS_FLAG_N])
      else $error("compare with carry borrow missing");
   imm_borrow_a: assert property (take && req.op == bcs_op_compare_immediate
      && req.rd_val < req.imm_val |=> res.flags_we && res.flags[`BCS_FLAG_C])
      else $error("compare immediate borrow missing");
   skip_two_word_a: assert property (take && req.op == bcs_op_skip_reg_bit_clear
      && !req.rr_val[req.bit_sel] && req.next_two_word |=> res.pc_next == $past(pc_in) + 16'h0003)
      else $error("skip over two-word instruction wrong");
   carry_branch_a: assert property (take && req.op == bcs_op_branch_carry_set
      && !status_flags_reg[`BCS_FLAG_C] |=> res.pc_next == $past(seq_pc))
      else $error("branch taken without carry");
   done_pulse_a: assert property (take |=> res.done ##1 !res.done && op_ready)
      else $error("result not a single pulse");
   // Skips must move past the next instruction and leave the status flags alone.
   reg_clear_skip_a: assert property (take && req.op == bcs_op_skip_reg_bit_clear
      && !req.rr_val[req.bit_sel] && !req.next_two_word
      |=> res.pc_next == $past(pc_in) + `BCS_SKIP_ONE && !res.flags_we)
      else $error("skip on cleared register bit wrong");
   reg_set_skip_a: assert property (take && req.op == bcs_op_skip_reg_bit_set
      && req.rr_val[req.bit_sel] && !req.next_two_word
      |=> res.pc_next == $past(pc_in) + `BCS_SKIP_ONE && !res.flags_we)
      else $error("skip on set register bit wrong");
   io_clear_skip_a: assert property (take && req.op == bcs_op_skip_io_bit_clear
      && !req.io_val[req.bit_sel] && req.next_two_word
      |=> res.pc_next == $past(pc_in) + `BCS_SKIP_TWO && !res.flags_we)
      else $error("skip on cleared io bit wrong");
   io_set_skip_a: assert property (take && req.op == bcs_op_skip_io_bit_set
      && req.io_val[req.bit_sel] && !req.next_two_word
      |=> res.pc_next == $past(pc_in) + `BCS_SKIP_ONE && !res.flags_we)
      else $error("skip on set io bit wrong");
   flag_clr_branch_a: assert property (take && req.op == bcs_op_branch_flag_clear
      && !status_flags_reg[req.bit_sel]
      |=> res.pc_next == $past(rel_pc) && !res.flags_we)
      else $error("branch on cleared flag target wrong");
   no_borrow_branch_a: assert property (take
      && req.op == bcs_op_branch_same_or_higher && !status_flags_reg[`BCS_FLAG_C]
      |=> res.pc_next == $past(rel_pc))
      else $error("branch without carry not taken");
   rel_jump_a: assert property (take && req.op == bcs_op_relative_jump
      |=> res.pc_next == $past(rel_pc) && !res.push_en && !res.flags_we)
      else $error("relative jump wrong");
   z_jump_a: assert property (take && req.op == bcs_op_indirect_jump
      |=> res.pc_next == $past(z_ptr) && !res.push_en && !res.pop_en && !res.flags_we)
      else $error("indirect jump wrong");
   // The offset checks rebuild the target from the raw offset, apart from the adder.
   back_offset_a: assert property (take && req.op == bcs_op_relative_jump
      && req.offset[`BCS_OFF_W-1]
      |=> res.pc_next + {{(`BCS_PC_W-`BCS_OFF_W){1'b0}}, ~$past(req.offset)} == $past(pc_in))
      else $error("backward jump target wrong");
   fwd_offset_a: assert property (take && req.op == bcs_op_relative_call
      && !req.offset[`BCS_OFF_W-1]
      |=> res.pc_next - $past(pc_in) - `BCS_PC_STEP
          == {{(`BCS_PC_W-`BCS_OFF_W){1'b0}}, $past(req.offset)})
      else $error("forward call target wrong");

   call_cov: cover property (take && req.op == bcs_op_relative_call);
   skip_cov: cover property (take && req.op == bcs_op_skip_io_bit_set && req.io_val[req.bit_sel]);
   back_branch_cov: cover property (take && req.op == bcs_op_relative_jump
      && req.offset[`BCS_OFF_W-1]);
   irq_return_cov: cover property (take && req.op == bcs_op_interrupt_return);
   carry_cmp_cov: cover property (take && req.op == bcs_op_compare_with_carry
      && status_flags_reg[`BCS_FLAG_C]);

endmodule

// ===== bcs_cfg.svh
/*
 * Constants for the control-flow execution block: program counter steps,
 * status flag bit positions and fixed widths.
 * Assumes it is included by its bare name from the package and the design.
 */
`ifndef BCS_CFG_SVH
`define BCS_CFG_SVH

`define BCS_PC_W 16
`define BCS_OFF_W 12
`define BCS_PC_STEP 16'h0001
`define BCS_SKIP_ONE 16'h0002
`define BCS_SKIP_TWO 16'h0003

`define BCS_FLAG_C 0
`define BCS_FLAG_Z 1
`define BCS_FLAG_N 2
`define BCS_FLAG_V 3
`define BCS_FLAG_S 4
`define BCS_FLAG_H 5
`define BCS_FLAG_T 6
`define BCS_FLAG_I 7

`define BCS_MSB 7
`define BCS_NIB_MSB 3
`define BCS_FLAGS_RST 8'h00
`define BCS_WORD_RST 16'h0000

`endif

// ===== bcs_pkg.sv
/*
 * Types shared by the control-flow execution block: operation codes,
 * sequencer states and the packed state record.
 * Assumes bcs_cfg.svh is on the include path.
 */
`include "bcs_cfg.svh"

package bcs_pkg;

   typedef enum logic [4:0] {
      bcs_op_none = 5'h00,
      bcs_op_relative_call = 5'h01,
      bcs_op_indirect_call = 5'h02,
      bcs_op_subroutine_return = 5'h03,
      bcs_op_interrupt_return = 5'h04,
      bcs_op_compare_skip_equal = 5'h05,
      bcs_op_compare_reg = 5'h06,
      bcs_op_compare_with_carry = 5'h07,
      bcs_op_compare_immediate = 5'h08,
      bcs_op_skip_reg_bit_clear = 5'h09,
      bcs_op_skip_reg_bit_set = 5'h0a,
      bcs_op_skip_io_bit_clear = 5'h0b,
      bcs_op_skip_io_bit_set = 5'h0c,
      bcs_op_branch_flag_set = 5'h0d,
      bcs_op_branch_flag_clear = 5'h0e,
      bcs_op_branch_carry_set = 5'h0f,
      bcs_op_branch_same_or_higher = 5'h10,
      bcs_op_relative_jump = 5'h11,
      bcs_op_indirect_jump = 5'h12
   } bcs_op_t;

   typedef enum logic [1:0] {
      bcs_st_idle = 2'h1,
      bcs_st_result = 2'h2
   } bcs_state_t;

   typedef struct packed {
      bcs_op_t op;
      logic [7:0] rd_val;
      logic [7:0] rr_val;
      logic [7:0] imm_val;
      logic [`BCS_OFF_W-1:0] offset;
      logic [2:0] bit_sel;
      logic [7:0] io_val;
      logic next_two_word;
   } bcs_req_t;

   typedef struct packed {
      logic done;
      logic pc_load;
      logic [`BCS_PC_W-1:0] pc_next;
      logic push_en;
      logic [`BCS_PC_W-1:0] push_data;
      logic pop_en;
      logic flags_we;
      logic [7:0] flags;
   } bcs_res_t;

   typedef struct packed {
      bcs_state_t st;
      bcs_res_t res;
   } bcs_core_t;

endpackage

// ===== bcs_exec_test.sv
/*
 * Self-checking bench for the control-flow execution block: a directed sweep
 * of every operation at offset and program counter extremes, a seeded random
 * run, a refused request and a reset in mid-result.
 * Assumes bcs_pkg and bcs_exec are compiled first and bcs_cfg.svh is reachable.
 */
module bcs_exec_test;
   timeunit 1ns;
   timeprecision 1ps;
   import bcs_pkg::*;

   logic clk;
   logic rst;
   logic op_valid;
   bcs_req_t req;
   logic op_ready;
   logic [15:0] pc_in;
   logic [15:0] z_ptr;
   logic [15:0] stack_top;
   logic [7:0] status_flags_reg;
   bcs_res_t res;
   int n_fail = 0;
   int checked = 0;
   int cycles = 0;
   int seed = 85899;

   bcs_exec bcs_exec_i (.clk(clk), .rst(rst), .op_valid(op_valid), .req(req),
      .op_ready(op_ready), .pc_in(pc_in), .z_ptr(z_ptr), .stack_top(stack_top),
      .status_flags_reg(status_flags_reg), .res(res));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Cuts a hang short; the whole run needs about nine hundred cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         end_sim();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   function automatic bcs_res_t expect_res(bcs_req_t q, logic [15:0] pc, logic [15:0] z,
                                           logic [15:0] st, logic [7:0] f);
      bcs_res_t e;
      logic [7:0] s;
      logic [7:0] r;
      logic [7:0] bw;
      logic take;
      logic skip;
      e = '0;
      e.done = 1'b1;
      e.pc_load = 1'b1;
      e.pc_next = pc + 16'h0001;
      e.flags = f;
      take = 1'b0;
      skip = 1'b0;
      s = (q.op == bcs_op_compare_immediate) ? q.imm_val : q.rr_val;
      r = q.rd_val - s - ((q.op == bcs_op_compare_with_carry) ? {7'h00, f[0]} : 8'h00);
      bw = (~q.rd_val & s) | (s & r) | (r & ~q.rd_val);
      case (q.op)
         bcs_op_relative_call, bcs_op_indirect_call: begin
            e.push_en = 1'b1;
            e.push_data = pc + 16'h0001;
            take = (q.op == bcs_op_relative_call);
            if (!take) e.pc_next = z;
         end
         bcs_op_subroutine_return, bcs_op_interrupt_return: begin
            e.pop_en = 1'b1;
            e.pc_next = st;
            if (q.op == bcs_op_interrupt_return) begin
               e.flags_we = 1'b1;
               e.flags[7] = 1'b1;
            end
         end
         bcs_op_compare_skip_equal: skip = (q.rd_val == q.rr_val);
         bcs_op_compare_reg, bcs_op_compare_with_carry, bcs_op_compare_immediate: begin
            e.flags_we = 1'b1;
            e.flags[0] = bw[7];
            e.flags[1] = (r == 8'h00) && (q.op != bcs_op_compare_with_carry || f[1]);
            e.flags[2] = r[7];
            e.flags[3] = (q.rd_val[7] & ~s[7] & ~r[7]) | (~q.rd_val[7] & s[7] & r[7]);
            e.flags[5] = bw[3];
         end
         bcs_op_skip_reg_bit_clear: skip = ~q.rr_val[q.bit_sel];
         bcs_op_skip_reg_bit_set: skip = q.rr_val[q.bit_sel];
         bcs_op_skip_io_bit_clear: skip = ~q.io_val[q.bit_sel];
         bcs_op_skip_io_bit_set: skip = q.io_val[q.bit_sel];
         bcs_op_branch_flag_set: take = f[q.bit_sel];
         bcs_op_branch_flag_clear: take = ~f[q.bit_sel];
         bcs_op_branch_carry_set: take = f[0];
         bcs_op_branch_same_or_higher: take = ~f[0];
         bcs_op_relative_jump: take = 1'b1;
         bcs_op_indirect_jump: e.pc_next = z;
         default: ;
      endcase
      if (take) e.pc_next = pc + 16'h0001 + {{4{q.offset[11]}}, q.offset};
      if (skip) e.pc_next = pc + (q.next_two_word ? 16'h0003 : 16'h0002);
      return e;
   endfunction

   // Takes one request and checks the result in the cycle that follows.
   task automatic run_op(input bcs_req_t q, input logic [15:0] pc, input logic [7:0] f);
      bcs_res_t e;
      logic [15:0] z;
      logic [15:0] st;
      z = 16'($random(seed));
      st = 16'($random(seed));
      e = expect_res(q, pc, z, st, f);
      @(posedge clk);
      #1;
      op_valid = 1'b1;
      req = q;
      pc_in = pc;
      z_ptr = z;
      stack_top = st;
      status_flags_reg = f;
      @(posedge clk);
      #1;
      op_valid = 1'b0;
      pc_in = ~pc;
      z_ptr = ~z;
      stack_top = ~st;
      status_flags_reg = ~f;
      chk(16'(op_ready), 16'h0000, "ready in result cycle");
      chk(16'({res.done, res.pc_load}), 16'h0003, "done and load");
      chk(res.pc_next, e.pc_next, "pc");
      chk(res.pc_next, e.pc_next, "pc");
      chk(res.pc_next, e.pc_next, "pc");
      chk(res.pc_next, e.pc_next, "pc");
      chk(16'({res.push_en, res.pop_en}), 16'({e.push_en, e.pop_en}), "stack");
      if (e.push_en) chk(res.push_data, e.push_data, "push data");
      chk(16'(res.flags_we), 16'(e.flags_we), "flag write");
      if (e.flags_we) chk(16'(res.flags), 16'(e.flags), "flags");
      if (e.flags_we) chk(16'(res.flags), 16'(e.flags), "flags");
   endtask

   initial begin
      bcs_req_t q;
      logic [63:0] rv;
      rst = 1'b1;
      op_valid = 1'b0;
      req = '0;
      pc_in = 16'h0000;
      z_ptr = 16'h0000;
      stack_top = 16'h0000;
      status_flags_reg = 8'h00;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      for (int j = 0; j < 2; j++) begin
         for (int i = 0; i < 21; i++) begin
            q = '0;
            q.op = bcs_op_t'(5'(i));
            q.offset = j ? 12'h7ff : 12'h800;
            q.bit_sel = j ? 3'h7 : 3'h0;
            q.rr_val = j ? 8'h80 : 8'h00;
            q.rd_val = q.rr_val;
            q.io_val = q.rr_val;
            q.next_two_word = j[0];
            run_op(q, j ? 16'hffff : 16'h0005, j ? 8'h00 : 8'hff);
         end
      end
      $display("directed sweep done");
      for (int n = 0; n < 400; n++) begin
         rv = {$random(seed), $random(seed)};
         q = rv[52:0];
         q.op = bcs_op_t'(5'($unsigned($random(seed)) % 21));
         if (rv[63]) q.rr_val = q.rd_val;
         if (rv[62]) q.imm_val = q.rd_val;
         if (q.op == bcs_op_skip_reg_bit_clear || q.op == bcs_op_skip_reg_bit_set) begin
            q.rd_val = q.rr_val;
         end
         run_op(q, 16'($random(seed)), 8'($random(seed)));
      end
      $display("random run done");
      q = '0;
      q.op = bcs_op_relative_jump;
      run_op(q, 16'h1234, 8'h00);
      op_valid = 1'b1;
      @(posedge clk);
      #1;
      op_valid = 1'b0;
      chk(16'(res.done), 16'h0000, "refused request answered");
      $display("refusal test done");
      run_op(q, 16'h4321, 8'h00);
      rst = 1'b1;
      #1;
      chk(16'(res === '0), 16'h0001, "result cleared by reset");
      chk(16'(op_ready), 16'h0001, "ready during reset");
      @(posedge clk);
      #1;
      rst = 1'b0;
      run_op(q, 16'h0100, 8'h01);
      $display("reset test done");
      end_sim();
   end
endmodule
